/* File: hw/ncm_datapath.sv */
// datapath core of the nibble controller: program store, data pairs, table
// pointer, accumulator, alu, status and carry flags
// assumes a sequencer outside drives the strobes, one instruction per strobe;
// all inputs but the asynchronous resetn synchronous to clk_sys; program store contents are loaded via prog_we
`timescale 1ns/1ns

// Function
// - program store holds 10-bit words addressed by the program counter
// - steps 3EAH to 3FFH are reserved for test, unusable by programs
// - fetch from unmounted or test area returns execution to 000H
// - data store is 32 four-bit words, also accessed as 8-bit pairs
// - reset clears pair 0; other pairs keep their contents
// - pair F shares storage with low return address bits
// - table pointer is pair 0 low byte plus control register zero bits 5:4
// - table pointer reads 000H after reset
// - accumulator is 4 bits and is not initialised by reset
// - alu works on 4-bit operands, logic first, simple arithmetic
// - status test sets flag when selected condition holds, else clears it
// - leaving standby through release sets the status flag
// - halt with release already true skips standby and sets flag
// - halt with flag set and no release clears flag, no standby
// - operand 000, 011, 110 test key pins; 101 tests timer zero
// - operand bit 3 also accepts a high on either sense pin
// - and/xor set carry only when both bit 3 inputs are one
// - rotate left variants load carry from old accumulator bit 3
// - increment variants set carry only when accumulator was 0FH
// - or always clears carry
// - move or port input into accumulator clears carry
// - control register zero resets to 0000 0011B
module ncm_datapath
  import ncm_pkg::*;
#(
  parameter logic [9:0] MOUNTED_LIMIT = MOUNTED_DEF
)(
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  // program store load and fetch
  input  wire logic             prog_we,
  input  wire logic [9:0]       prog_waddr,
  input  wire logic [9:0]       prog_wdata,
  input  wire logic             fetch_req,
  input  wire logic [9:0]       fetch_addr,
  output logic      [9:0]       fetch_word,
  output logic                  fetch_restart,
  output logic      [9:0]       restart_addr,
  // table read
  input  wire logic             table_req,
  output logic      [9:0]       table_word,
  output logic      [9:0]       table_pointer,
  // data store nibble and pair access
  input  wire logic             nib_we,
  input  wire logic [4:0]       nib_addr,
  input  wire logic [3:0]       nib_wdata,
  output logic      [3:0]       nib_rdata,
  input  wire logic             pair_we,
  input  wire logic [3:0]       pair_addr,
  input  wire logic [7:0]       pair_wdata,
  output logic      [7:0]       pair_rdata,
  // return address shadow
  input  wire logic             call_push,
  input  wire logic [9:0]       call_return_addr,
  output logic      [9:0]       return_address_stack,
  // control register zero
  input  wire logic             crz_we,
  input  wire logic [7:0]       crz_wdata,
  output logic      [7:0]       control_register_zero,
  // alu and accumulator
  input  wire logic             alu_go,
  input  wire ncm_pkg::ncm_op_t alu_op,
  input  wire logic [3:0]       alu_operand,
  output logic      [3:0]       acc,
  output logic                  carry_flag,
  // status flag and standby
  input  wire logic             status_test_go,
  input  wire logic [3:0]       status_test_op,
  input  wire logic [3:0]       key_input_pins,
  input  wire logic             sense_input_zero,
  input  wire logic             sense_input_one,
  input  wire logic             timer_zero,
  input  wire logic             halt_go,
  input  wire logic             release_cond,
  output logic                  status_flag,
  output logic                  standby
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // full address range; steps at or above the mounted limit stay unused
  logic [PROG_DW-1:0] prog_mem [0:(1<<PROG_AW)-1];
  // pair 0 sits in reset flops, pairs 1 to F in plain storage;
  // the bank arrays merge both so every reader sees all 16 pairs
  logic [3:0]         low_store  [1:PAIR_COUNT-1];
  logic [3:0]         high_store [1:PAIR_COUNT-1];
  logic [3:0]         table_lo;
  logic [3:0]         table_hi;
  logic [3:0]         low_bank  [0:PAIR_COUNT-1];
  logic [3:0]         high_bank [0:PAIR_COUNT-1];
  logic [1:0]         ras_hi;
  ncm_state_t         state;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when an address lies outside the usable program space
  function automatic logic addr_forbidden(input logic [9:0] a);
    addr_forbidden = (a >= MOUNTED_LIMIT) || ((a >= TEST_FIRST) && (a <= TEST_LAST));
  endfunction

  // one pair as a byte, high bank in the upper nibble
  function automatic logic [7:0] pair_of(input logic [3:0] idx, input logic [3:0] lo [0:15],
                                         input logic [3:0] hi [0:15]);
    pair_of = {hi[idx], lo[idx]};
  endfunction

  // unlisted low operand patterns never hit; only the sense bit can add one
  function automatic logic test_hit(input logic [3:0] opd, input logic [3:0] keys,
                                    input logic s0, input logic s1, input logic tz);
    logic hit;
    hit = 1'b0;
    if ((opd[2:0] == STT_KEY_A) || (opd[2:0] == STT_KEY_B) || (opd[2:0] == STT_KEY_C)) begin
      hit = |keys;
    end else if (opd[2:0] == STT_TIMER) begin
      hit = tz;
    end
    if (opd[STT_SENSE_BIT]) begin
      hit = hit | s0 | s1;
    end
    test_hit = hit;
  endfunction

  // ----------------------------------------------------------------
  // program store
  // ----------------------------------------------------------------
  // reserved test steps cannot be loaded; they hold no user content
  // no reset: the store keeps whatever was last loaded
  always_ff @(posedge clk_sys) begin
    if (clk_en && prog_we && !addr_forbidden(prog_waddr)) begin
      prog_mem[prog_waddr] <= prog_wdata;
    end
  end

  // a stray fetch gives a zero word and a one-cycle restart pulse;
  // the sequencer reloads its counter from restart_addr
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fetch_word    <= 10'h000;
      fetch_restart <= 1'b0;
    end else if (clk_en) begin
      fetch_restart <= 1'b0;
      if (fetch_req) begin
        if (addr_forbidden(fetch_addr)) begin
          fetch_word    <= 10'h000;
          fetch_restart <= 1'b1;
        end else begin
          fetch_word    <= prog_mem[fetch_addr];
        end
      end
    end
  end

  assign restart_addr = RESTART_ADDR;

  // ----------------------------------------------------------------
  // table pointer and table read
  // ----------------------------------------------------------------
  // pointer follows its sources at once, so a table read may come
  // in the cycle right after a pair 0 or control write
  always_comb begin
    table_pointer = {control_register_zero[CRZ_TP_HI:CRZ_TP_LO],
                     pair_of(PAIR_TABLE, low_bank, high_bank)};
  end

  // a pointer into the test area returns zero, same as a stray fetch
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      table_word <= 10'h000;
    end else if (clk_en && table_req) begin
      table_word <= addr_forbidden(table_pointer) ? 10'h000
                                                   : prog_mem[table_pointer];
    end
  end

  // ----------------------------------------------------------------
  // control register zero
  // ----------------------------------------------------------------
  // only bits 5:4 matter here; the rest serve port and timer logic
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      control_register_zero <= CRZ_RESET;
    end else if (clk_en && crz_we) begin
      control_register_zero <= crz_wdata;
    end
  end

  // ----------------------------------------------------------------
  // data store
  // ----------------------------------------------------------------
  // only pair 0 sees reset; others retain, so they have no reset branch.
  // separate variables for the two groups keep one driver for each.
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      for (int i = 1; i < PAIR_COUNT; i++) begin
        if (call_push && (4'(i) == PAIR_SHADOW)) begin
          low_store[i]  <= call_return_addr[3:0];
          high_store[i] <= call_return_addr[7:4];
        end else if (pair_we && (pair_addr == 4'(i))) begin
          low_store[i]  <= pair_wdata[3:0];
          high_store[i] <= pair_wdata[7:4];
        end else if (nib_we && (nib_addr[3:0] == 4'(i))) begin
          if (nib_addr[4]) begin
            high_store[i] <= nib_wdata;
          end else begin
            low_store[i]  <= nib_wdata;
          end
        end
      end
    end
  end

  // pair 0 also feeds the table pointer, hence the reset to zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      table_lo <= PAIR_RESET[3:0];
      table_hi <= PAIR_RESET[7:4];
    end else if (clk_en) begin
      if (pair_we && (pair_addr == PAIR_TABLE)) begin
        table_lo <= pair_wdata[3:0];
        table_hi <= pair_wdata[7:4];
      end else if (nib_we && (nib_addr[3:0] == PAIR_TABLE)) begin
        if (nib_addr[4]) begin
          table_hi <= nib_wdata;
        end else begin
          table_lo <= nib_wdata;
        end
      end
    end
  end

  // merged view read by the pointer, the pair and nibble ports and the shadow
  always_comb begin
    low_bank[PAIR_TABLE]  = table_lo;
    high_bank[PAIR_TABLE] = table_hi;
    for (int i = 1; i < PAIR_COUNT; i++) begin
      low_bank[i]  = low_store[i];
      high_bank[i] = high_store[i];
    end
  end

  assign nib_rdata  = nib_addr[4] ? high_bank[nib_addr[3:0]] : low_bank[nib_addr[3:0]];
  assign pair_rdata = pair_of(pair_addr, low_bank, high_bank);

  // high return bits live apart; the low byte is pair F itself
  // pair or nibble writes to F leave these two bits as they were
  always_ff @(posedge clk_sys) begin
    if (clk_en && call_push) begin
      ras_hi <= call_return_addr[9:8];
    end
  end

  assign return_address_stack = {ras_hi, pair_of(PAIR_SHADOW, low_bank, high_bank)};

  // ----------------------------------------------------------------
  // accumulator and carry
  // ----------------------------------------------------------------
  logic [3:0] alu_result;
  logic       alu_carry;
  logic       alu_carry_we;

  // the alu is combinational; acc and carry register its answer
  ncm_alu u_alu (
    .op        (alu_op),
    .acc       (acc),
    .operand   (alu_operand),
    .carry_in  (carry_flag),
    .result    (alu_result),
    .carry_out (alu_carry),
    .carry_we  (alu_carry_we)
  );

  // accumulator has no reset; its first value is whatever software loads
  always_ff @(posedge clk_sys) begin
    if (clk_en && alu_go && (alu_op != NCM_OP_NONE)) begin
      acc <= alu_result;
    end
  end

  // carry starts at zero so it is known; dec leaves it alone
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      carry_flag <= 1'b0;
    end else if (clk_en && alu_go && alu_carry_we) begin
      carry_flag <= alu_carry;
    end
  end

  // ----------------------------------------------------------------
  // status flag and standby
  // ----------------------------------------------------------------
  // a status test takes the cycle over a halt; in standby both are
  // ignored and only the release condition moves the state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      status_flag <= 1'b0;
      state       <= NCM_RUN;
    end else if (clk_en) begin
      unique case (state)
        NCM_RUN: begin
          if (status_test_go) begin
            status_flag <= test_hit(status_test_op, key_input_pins,
                                    sense_input_zero, sense_input_one,
                                    timer_zero);
          end else if (halt_go) begin
            if (release_cond) begin
              status_flag <= 1'b1;
            end else if (status_flag) begin
              status_flag <= 1'b0;
            end else begin
              state <= NCM_STANDBY;
            end
          end
        end
        NCM_STANDBY: begin
          if (release_cond) begin
            status_flag <= 1'b1;
            state       <= NCM_RUN;
          end
        end
        default: begin
          // an illegal code falls back to run
          state <= NCM_RUN;
        end
      endcase
    end
  end

  // decoded straight from the state register
  assign standby = (state == NCM_STANDBY);

endmodule

/* File: hw/ncm_pkg.sv */
// package for the nibble cpu datapath: field positions, reset values, opcodes
// assumes a single clock domain; used by ncm_datapath and ncm_alu
package ncm_pkg;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int unsigned PROG_AW       = 10;
  localparam int unsigned PROG_DW       = 10;
  localparam int unsigned DATA_WORDS    = 32;
  localparam int unsigned PAIR_COUNT    = 16;
  localparam int unsigned NIB_W         = 4;
  localparam logic [9:0]  PROG_TOP_USER = 10'h3E9;
  localparam logic [9:0]  TEST_FIRST    = 10'h3EA;
  localparam logic [9:0]  TEST_LAST     = 10'h3FF;
  localparam logic [9:0]  RESTART_ADDR  = 10'h000;
  localparam logic [9:0]  MOUNTED_DEF   = 10'h3EA;
  localparam logic [3:0]  PAIR_TABLE    = 4'h0;
  localparam logic [3:0]  PAIR_SHADOW   = 4'hF;
  localparam logic [7:0]  PAIR_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // control register zero
  // ----------------------------------------------------------------
  localparam logic [7:0]  CRZ_RESET     = 8'h03;
  localparam int unsigned CRZ_TP_LO     = 4;
  localparam int unsigned CRZ_TP_HI     = 5;

  // ----------------------------------------------------------------
  // status test operand and all-ones accumulator value
  // ----------------------------------------------------------------
  localparam int unsigned STT_SENSE_BIT = 3;
  localparam logic [2:0]  STT_KEY_A     = 3'h0;
  localparam logic [2:0]  STT_KEY_B     = 3'h3;
  localparam logic [2:0]  STT_KEY_C     = 3'h6;
  localparam logic [2:0]  STT_TIMER     = 3'h5;
  localparam logic [3:0]  ACC_ALL_ONES  = 4'hF;

  // ----------------------------------------------------------------
  // alu operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    NCM_OP_NONE     = 4'h0,
    NCM_OP_AND      = 4'h1,
    NCM_OP_XOR      = 4'h2,
    NCM_OP_OR       = 4'h3,
    NCM_OP_ROL      = 4'h4,
    NCM_OP_ROLZ     = 4'h5,
    NCM_OP_INC      = 4'h6,
    NCM_OP_CINC     = 4'h7,
    NCM_OP_MOV      = 4'h8,
    NCM_OP_IN       = 4'h9,
    NCM_OP_DEC      = 4'hA
  } ncm_op_t;

  typedef enum logic [1:0] {
    NCM_RUN         = 2'h0,
    NCM_STANDBY     = 2'h1
  } ncm_state_t;

endpackage

/* File: hw/ncm_alu.sv */
// 4-bit alu with carry generation
// assumes operands are valid in the cycle that op is presented; purely combinational
`timescale 1ns/1ns

module ncm_alu
  import ncm_pkg::*;
(
  input  wire ncm_pkg::ncm_op_t op,
  input  wire logic [3:0]       acc,
  input  wire logic [3:0]       operand,
  input  wire logic             carry_in,
  output logic      [3:0]       result,
  output logic                  carry_out,
  output logic                  carry_we
);

  always_comb begin
    result    = acc;
    carry_out = carry_in;
    carry_we  = 1'b1;
    unique case (op)
      NCM_OP_AND: begin
        result    = acc & operand;
        carry_out = acc[3] & operand[3];
      end
      NCM_OP_XOR: begin
        result    = acc ^ operand;
        carry_out = acc[3] & operand[3];
      end
      NCM_OP_OR: begin
        result    = acc | operand;
        carry_out = 1'b0;
      end
      NCM_OP_ROL: begin
        result    = {acc[2:0], acc[3]};
        carry_out = acc[3];
      end
      NCM_OP_ROLZ: begin
        result    = {acc[2:0], 1'b0};
        carry_out = acc[3];
      end
      NCM_OP_INC, NCM_OP_CINC: begin
        result    = acc + 4'h1;
        carry_out = (acc == ACC_ALL_ONES);
      end
      NCM_OP_MOV, NCM_OP_IN: begin
        result    = operand;
        carry_out = 1'b0;
      end
      NCM_OP_DEC: begin
        result    = acc - 4'h1;
        carry_we  = 1'b0;
      end
      default: begin
        carry_we  = 1'b0;
      end
    endcase
  end

endmodule

/* File: testbench/ncm_assertions.sv */
// checker bound to ncm_datapath: restart, pointer, carry and status flag relations
// assumes one clock domain and sees only the datapath's ports
`timescale 1ns/1ns
module ncm_checker
  import ncm_pkg::*;
#(
  parameter logic [9:0] MOUNTED_LIMIT = MOUNTED_DEF
)(
  input wire logic             clk_sys,
  input wire logic             resetn,
  input wire logic             clk_en,
  input wire logic             fetch_req,
  input wire logic [9:0]       fetch_addr,
  input wire logic [9:0]       fetch_word,
  input wire logic             fetch_restart,
  input wire logic [9:0]       table_pointer,
  input wire logic [3:0]       pair_addr,
  input wire logic [7:0]       pair_rdata,
  input wire logic [7:0]       control_register_zero,
  input wire logic             alu_go,
  input wire ncm_pkg::ncm_op_t alu_op,
  input wire logic [3:0]       alu_operand,
  input wire logic [3:0]       acc,
  input wire logic             carry_flag,
  input wire logic             status_test_go,
  input wire logic             halt_go,
  input wire logic             release_cond,
  input wire logic             status_flag,
  input wire logic             standby
);
  // ----------------------------------------------------------------
  // relations
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic alu_t;
  logic halt_t;
  assign alu_t  = alu_go && clk_en;
  // a status test wins the cycle, and standby ignores halt
  assign halt_t = halt_go && clk_en && !status_test_go && !standby;

  a_restart_forbidden:
    assert property (fetch_req && clk_en && (fetch_addr >= MOUNTED_LIMIT || fetch_addr >= TEST_FIRST)
      |=> fetch_restart && fetch_word == 10'h000) else $error("forbidden fetch kept running");
  a_pointer_formed:
    assert property (pair_addr == PAIR_TABLE |-> table_pointer ==
      {control_register_zero[CRZ_TP_HI:CRZ_TP_LO], pair_rdata}) else $error("table pointer wrong");
  a_and_xor_carry:
    assert property (alu_t && alu_op inside {NCM_OP_AND, NCM_OP_XOR}
      |=> carry_flag == ($past(acc[3]) & $past(alu_operand[3]))) else $error("and/xor carry wrong");
  a_rotate_carry:
    assert property (alu_t && alu_op inside {NCM_OP_ROL, NCM_OP_ROLZ}
      |=> carry_flag == $past(acc[3])) else $error("rotate carry wrong");
  a_inc_carry:
    assert property (alu_t && alu_op inside {NCM_OP_INC, NCM_OP_CINC}
      |=> carry_flag == ($past(acc) == ACC_ALL_ONES)) else $error("increment carry wrong");
  a_carry_cleared:
    assert property (alu_t && alu_op inside {NCM_OP_OR, NCM_OP_MOV, NCM_OP_IN}
      |=> !carry_flag) else $error("carry not cleared");
  a_leave_standby:
    assert property (standby && release_cond && clk_en ##1 1'b1 |-> !standby && status_flag)
      else $error("standby release did not set flag");
  a_halt_skip:
    assert property (halt_t && release_cond |=> status_flag && !standby)
      else $error("halt with release entered standby");
  a_halt_clear:
    assert property (halt_t && !release_cond && status_flag |=> !status_flag && !standby)
      else $error("halt with flag set misbehaved");
endmodule

bind ncm_datapath ncm_checker #(.MOUNTED_LIMIT(MOUNTED_LIMIT)) chk_u (.*);

/* File: testbench/testbench.sv */
// self-checking bench for ncm_datapath: memories, pointer, carry and status flag
// assumes the checker file is compiled alongside and binds itself to the datapath
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench;
  import ncm_pkg::*;
  typedef struct {int sel; logic [9:0] val; int due;} ncm_note_t;
  // smaller part, so an unmounted range sits below the test area
  localparam logic [9:0] LIMIT = 10'h200;
  logic       clk_sys = 0, resetn = 0, clk_en = 1, prog_we = 0, fetch_req = 0, table_req = 0;
  logic       nib_we = 0, pair_we = 0, call_push = 0, crz_we = 0, alu_go = 0, halt_go = 0;
  logic       status_test_go = 0, release_cond = 0, timer_zero = 0;
  logic       sense_input_zero = 0, sense_input_one = 0, c;
  logic [9:0] prog_waddr = '0, prog_wdata = '0, fetch_addr = '0, call_return_addr = '0;
  logic [4:0] nib_addr = '0;
  logic [3:0] nib_wdata = '0, pair_addr = '0, alu_operand = '0, status_test_op = '0;
  logic [3:0] key_input_pins = '0, h, l, x, k;
  logic [7:0] pair_wdata = '0, crz_wdata = '0;
  ncm_op_t    alu_op = NCM_OP_NONE;
  logic [9:0] fetch_word, restart_addr, table_word, table_pointer, return_address_stack, a, d;
  logic       fetch_restart, carry_flag, status_flag, standby;
  logic [3:0] nib_rdata, acc;
  logic [7:0] pair_rdata, control_register_zero;
  logic [7:0] mem [0:15];
  int         cyc = 0, err_total = 0, n_compared = 0, i, n;
  integer     seed = 32'hE4F24FFC;
  ncm_note_t  notes[$];
  ncm_note_t  nt;
  ncm_op_t    ops [0:8] = '{NCM_OP_AND, NCM_OP_XOR, NCM_OP_OR, NCM_OP_ROL, NCM_OP_ROLZ,
                            NCM_OP_INC, NCM_OP_CINC, NCM_OP_MOV, NCM_OP_IN};
  logic [2:0] lows [0:3] = '{STT_KEY_A, STT_KEY_B, STT_KEY_C, STT_TIMER};

  ncm_datapath #(.MOUNTED_LIMIT(LIMIT)) dut_u (.*);

  // ----------------------------------------------------------------
  // clock, cycle count and result watcher
  // ----------------------------------------------------------------
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  function automatic logic [9:0] got_of(int s);
    case (s)
      0: return fetch_word;
      1: return {9'h000, fetch_restart};
      2: return table_word;
      3: return table_pointer;
      4: return {2'h0, pair_rdata};
      5: return {6'h00, acc};
      6: return {9'h000, carry_flag};
      7: return {9'h000, status_flag};
      8: return {9'h000, standby};
      9: return {6'h00, nib_rdata};
      10: return return_address_stack;
      11: return {2'h0, control_register_zero};
      default: return restart_addr;
    endcase
  endfunction

  // notes are due at a cycle count, compared once the outputs have settled
  always @(negedge clk_sys) begin
    while (notes.size() > 0 && notes[0].due <= cyc) begin
      nt = notes.pop_front();
      `CHK(got_of(nt.sel), nt.val)
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task tick; @(posedge clk_sys); endtask
  task note(int s, logic [9:0] v, int lag); notes.push_back('{s, v, cyc + lag}); endtask
  task fin;
    tick;
    {prog_we, fetch_req, table_req, nib_we, pair_we, call_push, crz_we, alu_go,
     status_test_go, halt_go} <= '0;
  endtask
  task pair_chk(logic [3:0] p, logic [7:0] v);
    tick;
    pair_addr <= p;
    note(4, {2'h0, v}, 1);
  endtask
  task alu(ncm_op_t op, logic [3:0] v, logic cy);
    tick;
    alu_go <= 1'b1;
    alu_op <= op;
    alu_operand <= v;
    note(6, {9'h000, cy}, 2);
    fin;
  endtask
  task stt(logic [3:0] op, logic [3:0] kp, logic s0, logic s1, logic tz, logic f);
    tick;
    status_test_go <= 1'b1;
    status_test_op <= op;
    key_input_pins <= kp;
    {sense_input_zero, sense_input_one, timer_zero} <= {s0, s1, tz};
    note(7, {9'h000, f}, 2);
    fin;
  endtask
  task halt(logic rel, logic f, logic sb);
    tick;
    halt_go <= 1'b1;
    release_cond <= rel;
    note(7, {9'h000, f}, 2);
    note(8, {9'h000, sb}, 2);
    fin;
  endtask

  task give_verdict;
    if (notes.size() > 0) err_total++;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) tick;
    err_total++;
    give_verdict;
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) tick;
    resetn <= 1'b1;
    note(11, 10'h003, 1);
    note(3, 10'h000, 1);
    note(4, 10'h000, 1);
    for (i = 0; i < 6; i++) begin
      a = {1'b0, 9'($random(seed))};
      d = 10'($random(seed));
      tick;
      prog_we <= 1'b1;
      {prog_waddr, prog_wdata} <= {a, d};
      fin;
      tick;
      {fetch_req, fetch_addr} <= {1'b1, a};
      note(0, d, 2);
      fin;
      tick;
      {crz_we, crz_wdata} <= {1'b1, 2'h0, a[9:8], 4'($random(seed))};
      {pair_we, pair_addr, pair_wdata} <= {1'b1, 4'h0, a[7:0]};
      fin;
      tick;
      table_req <= 1'b1;
      note(3, a, 1);
      note(2, d, 2);
      fin;
    end
    foreach (ops[j]) begin
      a = (j < 2) ? 10'h3EA + 10'(j * 21) : LIMIT + 10'(j * 50);
      tick;
      {prog_we, prog_waddr, prog_wdata} <= {1'b1, a, 10'h155};
      fin;
      tick;
      {fetch_req, fetch_addr} <= {1'b1, a};
      note(1, 10'h001, 2);
      note(0, 10'h000, 2);
      note(12, 10'h000, 2);
      fin;
    end
    for (n = 0; n < 16; n++) begin
      {h, l} = 8'($random(seed));
      mem[n] = {h, l};
      tick;
      {nib_we, nib_addr, nib_wdata} <= {1'b1, 1'b1, 4'(n), h};
      fin;
      tick;
      {nib_we, nib_addr, nib_wdata} <= {1'b1, 1'b0, 4'(n), l};
      fin;
      pair_chk(4'(n), {h, l});
      tick;
      nib_addr <= {1'b1, 4'(n)};
      note(9, {6'h00, h}, 1);
    end
    tick;
    resetn <= 1'b0;
    repeat (2) tick;
    resetn <= 1'b1;
    note(11, 10'h003, 1);
    note(3, 10'h000, 1);
    pair_chk(4'h0, 8'h00);
    for (n = 1; n < 16; n++) pair_chk(4'(n), mem[n]);
    a = 10'($random(seed));
    tick;
    {call_push, call_return_addr} <= {1'b1, a};
    fin;
    pair_chk(4'hF, a[7:0]);
    note(10, a, 1);
    for (i = 0; i < 36; i++) begin
      h = (i < 9) ? 4'hF : 4'($random(seed));
      x = (i < 9) ? 4'h8 : 4'($random(seed));
      alu(NCM_OP_MOV, h, 1'b0);
      note(5, {6'h00, h}, 1);
      case (ops[i % 9])
        NCM_OP_AND, NCM_OP_XOR: c = h[3] & x[3];
        NCM_OP_ROL, NCM_OP_ROLZ: c = h[3];
        NCM_OP_INC, NCM_OP_CINC: c = (h == 4'hF);
        default: c = 1'b0;
      endcase
      alu(ops[i % 9], x, c);
    end
    alu(NCM_OP_MOV, 4'hF, 1'b0);
    alu(NCM_OP_INC, 4'h0, 1'b1);
    alu(NCM_OP_DEC, 4'h0, 1'b1);
    note(5, 10'h00F, 1);
    for (i = 0; i < 32; i++) begin
      k = i[3] ? 4'($random(seed)) : 4'h0;
      {h[0], h[1], h[2]} = 3'($random(seed));
      c = (i[1:0] == 2'h3 ? h[2] : |k) | (i[2] & (h[0] | h[1]));
      stt({i[2], lows[i[1:0]]}, k, h[0], h[1], h[2], c);
    end
    stt(4'h1, 4'hF, 1'b0, 1'b0, 1'b1, 1'b0);
    stt(4'h9, 4'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    stt(4'h0, 4'hF, 1'b0, 1'b0, 1'b0, 1'b1);
    halt(1'b0, 1'b0, 1'b0);
    halt(1'b0, 1'b0, 1'b1);
    stt(4'h0, 4'hF, 1'b0, 1'b0, 1'b0, 1'b0);
    note(8, 10'h001, 1);
    tick;
    release_cond <= 1'b1;
    note(8, 10'h000, 2);
    note(7, 10'h001, 2);
    tick;
    release_cond <= 1'b0;
    stt(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    halt(1'b1, 1'b1, 1'b0);
    repeat (4) tick;
    give_verdict;
  end
endmodule
